// ---- include/iem_pkg.sv ----
// Constants for the second interrupt enable mask word, bits 13 to 1
package iem_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SRC_N  = 8;

    typedef logic [ADDR_W-1:0] iem_addr_t;
    typedef logic [DATA_W-1:0] iem_data_t;
    typedef logic [SRC_N-1:0]  iem_src_t;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam iem_addr_t OFS_MASK = 8'h00;
    localparam iem_addr_t OFS_PEND = 8'h04;
    localparam iem_addr_t OFS_REQ  = 8'h08;

    // ------------------------------------------------------------
    // Field positions in the mask word
    // ------------------------------------------------------------
    localparam int unsigned BIT_CMP1   = 13;
    localparam int unsigned BIT_PINCHG = 11;
    localparam int unsigned BIT_PG4    = 6;
    localparam int unsigned BIT_PG3    = 5;
    localparam int unsigned BIT_PG2    = 4;
    localparam int unsigned BIT_PG1    = 3;
    localparam int unsigned BIT_SPMAT  = 2;
    localparam int unsigned BIT_EXT2   = 1;

    // ------------------------------------------------------------
    // Source index order in the packed source vectors
    // ------------------------------------------------------------
    localparam int unsigned SRC_CMP1   = 7;
    localparam int unsigned SRC_PINCHG = 6;
    localparam int unsigned SRC_PG4    = 5;
    localparam int unsigned SRC_PG3    = 4;
    localparam int unsigned SRC_PG2    = 3;
    localparam int unsigned SRC_PG1    = 2;
    localparam int unsigned SRC_SPMAT  = 1;
    localparam int unsigned SRC_EXT2   = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam iem_src_t  EN_RST   = 8'h00;
    localparam iem_src_t  REQ_RST  = 8'h00;
    localparam iem_data_t RD_IDLE  = 16'h0000;

    // Word bits to source vector
    function automatic iem_src_t iem_word_to_src(input iem_data_t w);
        iem_src_t s;
        s = EN_RST;
        s[SRC_CMP1]   = w[BIT_CMP1];
        s[SRC_PINCHG] = w[BIT_PINCHG];
        s[SRC_PG4]    = w[BIT_PG4];
        s[SRC_PG3]    = w[BIT_PG3];
        s[SRC_PG2]    = w[BIT_PG2];
        s[SRC_PG1]    = w[BIT_PG1];
        s[SRC_SPMAT]  = w[BIT_SPMAT];
        s[SRC_EXT2]   = w[BIT_EXT2];
        return s;
    endfunction : iem_word_to_src

    // Source vector to word; all other bits read zero
    function automatic iem_data_t iem_src_to_word(input iem_src_t s);
        iem_data_t w;
        w = RD_IDLE;
        w[BIT_CMP1]   = s[SRC_CMP1];
        w[BIT_PINCHG] = s[SRC_PINCHG];
        w[BIT_PG4]    = s[SRC_PG4];
        w[BIT_PG3]    = s[SRC_PG3];
        w[BIT_PG2]    = s[SRC_PG2];
        w[BIT_PG1]    = s[SRC_PG1];
        w[BIT_SPMAT]  = s[SRC_SPMAT];
        w[BIT_EXT2]   = s[SRC_EXT2];
        return w;
    endfunction : iem_src_to_word

endpackage : iem_pkg

// ---- rtl/iem_req_gate.sv ----
// Per-source request gating: pending AND enable, registered
`timescale 1ns/1ps
module iem_req_gate
    import iem_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // Sources
    input  wire iem_pkg::iem_src_t pend_i,
    input  wire iem_pkg::iem_src_t en_i,
    // Requests
    output iem_pkg::iem_src_t      req_o,
    output logic                   any_o
);
    import iem_pkg::*;

    iem_src_t req_d;
    iem_src_t req_q;
    logic     any_q;

    // ------------------------------------------------------------
    // Gating
    // ------------------------------------------------------------
    // Enable only masks; the pending flag is never touched here
    assign req_d = pend_i & en_i;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            req_q <= REQ_RST;
            any_q <= 1'b0;
        end else begin
            req_q <= req_d;
            any_q <= |req_d;
        end
    end

    assign req_o = req_q;
    assign any_o = any_q;

endmodule : iem_req_gate

// ---- rtl/iem_mask_bank_one.sv ----
// Interrupt enable mask word, bits 13 down to 1, with request gating
// ------------------------------------------------------------
// What this block does
// - Bit 13 enables the first analog comparator request.
// - Bits 12 and 10 to 7 have no storage, read zero, ignore writes.
// - Bit 11 enables the input change notification request.
// - Bits 6, 5, 4, 3 enable pulse generators four, three, two, one.
// - Bit 2 enables the pulse time base special event match request.
// - A one in an enable bit passes the request and a zero blocks it.
// ------------------------------------------------------------
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module iem_mask_bank_one
    import iem_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // Register port
    input  wire iem_pkg::iem_addr_t reg_addr_i,
    input  wire iem_pkg::iem_data_t reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output iem_pkg::iem_data_t     reg_rdata_o,
    // Pending flags from the sources
    input  wire logic              comparator_one_pend_i,
    input  wire logic              pin_change_pend_i,
    input  wire logic              pulse_gen_four_pend_i,
    input  wire logic              pulse_gen_three_pend_i,
    input  wire logic              pulse_gen_two_pend_i,
    input  wire logic              pulse_gen_one_pend_i,
    input  wire logic              pulse_special_match_pend_i,
    input  wire logic              ext_line_two_pend_i,
    // Enable levels
    output logic                   comparator_one_irq_en_o,
    output logic                   pin_change_irq_en_o,
    output logic                   pulse_gen_four_irq_en_o,
    output logic                   pulse_gen_three_irq_en_o,
    output logic                   pulse_gen_two_irq_en_o,
    output logic                   pulse_gen_one_irq_en_o,
    output logic                   pulse_special_match_irq_en_o,
    output logic                   ext_line_two_irq_en_o,
    // Gated requests to the controller
    output logic                   comparator_one_req_o,
    output logic                   pin_change_req_o,
    output logic                   pulse_gen_four_req_o,
    output logic                   pulse_gen_three_req_o,
    output logic                   pulse_gen_two_req_o,
    output logic                   pulse_gen_one_req_o,
    output logic                   pulse_special_match_req_o,
    output logic                   ext_line_two_req_o,
    output logic                   any_req_o
);
    import iem_pkg::*;

    // ------------------------------------------------------------
    // Enable storage
    // ------------------------------------------------------------
    iem_src_t  en_q;
    iem_src_t  en_d;
    iem_src_t  pend;
    iem_src_t  req;
    iem_data_t rdata_q;
    iem_data_t rdata_d;

    logic      sel_mask;
    logic      sel_pend;
    logic      sel_req;
    logic      wr_mask;
    logic      rd_mask;
    logic      rd_pend;
    logic      rd_req;

    iem_src_t  wr_fields;
    logic      wr_cmp1;
    logic      wr_pinchg;
    logic      wr_pg4;
    logic      wr_pg3;
    logic      wr_pg2;
    logic      wr_pg1;
    logic      wr_spmat;
    logic      wr_ext2;

    iem_data_t mask_word;
    iem_data_t pend_word;
    iem_data_t req_word;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Full byte compare; any other address is simply not selected
    assign sel_mask = (reg_addr_i == OFS_MASK);
    assign sel_pend = (reg_addr_i == OFS_PEND);
    assign sel_req  = (reg_addr_i == OFS_REQ);
    assign wr_mask  = reg_wr_i & sel_mask;
    assign rd_mask  = reg_rd_i & sel_mask;
    assign rd_pend  = reg_rd_i & sel_pend;
    assign rd_req   = reg_rd_i & sel_req;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Only the eight implemented bits are kept; the rest fall away
    assign wr_fields = iem_word_to_src(reg_wdata_i);

    assign wr_cmp1   = wr_fields[SRC_CMP1];
    assign wr_pinchg = wr_fields[SRC_PINCHG];
    assign wr_pg4    = wr_fields[SRC_PG4];
    assign wr_pg3    = wr_fields[SRC_PG3];
    assign wr_pg2    = wr_fields[SRC_PG2];
    assign wr_pg1    = wr_fields[SRC_PG1];
    assign wr_spmat  = wr_fields[SRC_SPMAT];
    assign wr_ext2   = wr_fields[SRC_EXT2];

    // A write to another address leaves every field as it was
    assign en_d[SRC_CMP1]   = wr_mask ? wr_cmp1   : en_q[SRC_CMP1];
    assign en_d[SRC_PINCHG] = wr_mask ? wr_pinchg : en_q[SRC_PINCHG];
    assign en_d[SRC_PG4]    = wr_mask ? wr_pg4    : en_q[SRC_PG4];
    assign en_d[SRC_PG3]    = wr_mask ? wr_pg3    : en_q[SRC_PG3];
    assign en_d[SRC_PG2]    = wr_mask ? wr_pg2    : en_q[SRC_PG2];
    assign en_d[SRC_PG1]    = wr_mask ? wr_pg1    : en_q[SRC_PG1];
    assign en_d[SRC_SPMAT]  = wr_mask ? wr_spmat  : en_q[SRC_SPMAT];
    assign en_d[SRC_EXT2]   = wr_mask ? wr_ext2   : en_q[SRC_EXT2];

    // ------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            en_q <= EN_RST;
        end else begin
            en_q <= en_d;
        end
    end

    // ------------------------------------------------------------
    // Source packing
    // ------------------------------------------------------------
    // Sources share this clock, so no synchroniser sits here
    assign pend[SRC_CMP1]   = comparator_one_pend_i;
    assign pend[SRC_PINCHG] = pin_change_pend_i;
    assign pend[SRC_PG4]    = pulse_gen_four_pend_i;
    assign pend[SRC_PG3]    = pulse_gen_three_pend_i;
    assign pend[SRC_PG2]    = pulse_gen_two_pend_i;
    assign pend[SRC_PG1]    = pulse_gen_one_pend_i;
    assign pend[SRC_SPMAT]  = pulse_special_match_pend_i;
    assign pend[SRC_EXT2]   = ext_line_two_pend_i;

    // ------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------
    // Registered, so a mask rewrite never glitches a request
    iem_req_gate u_gate (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pend_i     (pend),
        .en_i       (en_q),
        .req_o      (req),
        .any_o      (any_req_o)
    );

    // ------------------------------------------------------------
    // Request outputs
    // ------------------------------------------------------------
    // One cycle behind pending AND enable
    assign comparator_one_req_o      = req[SRC_CMP1];
    assign pin_change_req_o          = req[SRC_PINCHG];
    assign pulse_gen_four_req_o      = req[SRC_PG4];
    assign pulse_gen_three_req_o     = req[SRC_PG3];
    assign pulse_gen_two_req_o       = req[SRC_PG2];
    assign pulse_gen_one_req_o       = req[SRC_PG1];
    assign pulse_special_match_req_o = req[SRC_SPMAT];
    assign ext_line_two_req_o        = req[SRC_EXT2];

    // ------------------------------------------------------------
    // Enable outputs
    // ------------------------------------------------------------
    // Plain flop outputs, nothing gated on the way out
    assign comparator_one_irq_en_o      = en_q[SRC_CMP1];
    assign pin_change_irq_en_o          = en_q[SRC_PINCHG];
    assign pulse_gen_four_irq_en_o      = en_q[SRC_PG4];
    assign pulse_gen_three_irq_en_o     = en_q[SRC_PG3];
    assign pulse_gen_two_irq_en_o       = en_q[SRC_PG2];
    assign pulse_gen_one_irq_en_o       = en_q[SRC_PG1];
    assign pulse_special_match_irq_en_o = en_q[SRC_SPMAT];
    assign ext_line_two_irq_en_o        = en_q[SRC_EXT2];

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Words are built every cycle; only the strobe picks one
    assign mask_word = iem_src_to_word(en_q);
    assign pend_word = iem_src_to_word(pend);
    assign req_word  = iem_src_to_word(req);

    // Data only in the cycle after the strobe; zero otherwise
    always_comb begin
        rdata_d = RD_IDLE;
        if (rd_mask) begin
            rdata_d = mask_word;
        end else if (rd_pend) begin
            rdata_d = pend_word;
        end else if (rd_req) begin
            rdata_d = req_word;
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= RD_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule : iem_mask_bank_one

// ---- verification/iem_mask_bank_one_props.sv ----
// Port checks for the enable mask block
`timescale 1ns/1ps
module iem_mask_bank_one_props
    import iem_pkg::*;
(
    // Clock, reset and register port
    input wire logic               core_clk_i,
    input wire logic               rst_n_i,
    input wire iem_pkg::iem_addr_t reg_addr_i,
    input wire iem_pkg::iem_data_t reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire iem_pkg::iem_data_t reg_rdata_o,
    // Source side
    input wire logic               comparator_one_pend_i,
    input wire logic               comparator_one_irq_en_o,
    input wire logic               comparator_one_req_o,
    input wire logic               pin_change_req_o,
    input wire logic               pulse_gen_four_req_o,
    input wire logic               pulse_gen_three_req_o,
    input wire logic               pulse_gen_two_req_o,
    input wire logic               pulse_gen_one_req_o,
    input wire logic               pulse_special_match_req_o,
    input wire logic               ext_line_two_req_o,
    input wire logic               pin_change_irq_en_o,
    input wire logic               pulse_gen_four_irq_en_o,
    input wire logic               pulse_special_match_irq_en_o,
    input wire logic               ext_line_two_irq_en_o,
    input wire logic               any_req_o
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence mask_wr;
        reg_wr_i && reg_addr_i == OFS_MASK;
    endsequence
    sequence mask_rd;
        reg_rd_i && reg_addr_i == OFS_MASK;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cmp_en_wr: assert property (
        mask_wr |=> comparator_one_irq_en_o == $past(reg_wdata_i[13]))
        else $error("comparator enable not taken from bit 13");
    a_pin_en_wr: assert property (
        mask_wr |=> pin_change_irq_en_o == $past(reg_wdata_i[11]))
        else $error("pin change enable not taken from bit 11");
    a_pg4_en_wr: assert property (
        mask_wr |=> pulse_gen_four_irq_en_o == $past(reg_wdata_i[6]))
        else $error("generator four enable not taken from bit 6");
    a_spm_en_wr: assert property (
        mask_wr |=> pulse_special_match_irq_en_o == $past(reg_wdata_i[2]))
        else $error("match enable not taken from bit 2");
    a_ext_en_wr: assert property (
        mask_wr |=> ext_line_two_irq_en_o == $past(reg_wdata_i[1]))
        else $error("line two enable not taken from bit 1");
    a_unimpl_zero: assert property (
        mask_rd |=> (reg_rdata_o & 16'hd781) == 16'h0000)
        else $error("unstored mask bit read nonzero");
    a_rd_echo: assert property (
        mask_rd |=> reg_rdata_o[13] == $past(comparator_one_irq_en_o))
        else $error("mask read does not echo enable");
    a_rd_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside its cycle");
    a_req_gate: assert property (
        $past(rst_n_i) |-> comparator_one_req_o ==
            $past(comparator_one_pend_i && comparator_one_irq_en_o))
        else $error("request is not pending and enable");
    a_any_req: assert property (
        any_req_o == (comparator_one_req_o || pin_change_req_o ||
            pulse_gen_four_req_o || pulse_gen_three_req_o ||
            pulse_gen_two_req_o || pulse_gen_one_req_o ||
            pulse_special_match_req_o || ext_line_two_req_o))
        else $error("summary request is not the OR of requests");
endmodule : iem_mask_bank_one_props

// ---- verification/iem_mask_bank_one_tb.sv ----
// Self-checking bench for the enable mask block
`timescale 1ns/1ps
module iem_mask_bank_one_tb;
    import iem_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic      core_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
    iem_addr_t reg_addr_i;
    iem_data_t reg_wdata_i, reg_rdata_o, w;
    logic      comparator_one_pend_i, pin_change_pend_i,
               pulse_gen_four_pend_i, pulse_gen_three_pend_i,
               pulse_gen_two_pend_i, pulse_gen_one_pend_i,
               pulse_special_match_pend_i, ext_line_two_pend_i;
    logic      comparator_one_irq_en_o, pin_change_irq_en_o,
               pulse_gen_four_irq_en_o, pulse_gen_three_irq_en_o,
               pulse_gen_two_irq_en_o, pulse_gen_one_irq_en_o,
               pulse_special_match_irq_en_o, ext_line_two_irq_en_o;
    logic      comparator_one_req_o, pin_change_req_o,
               pulse_gen_four_req_o, pulse_gen_three_req_o,
               pulse_gen_two_req_o, pulse_gen_one_req_o,
               pulse_special_match_req_o, ext_line_two_req_o, any_req_o;
    logic [7:0] pend_q;
    int         error_cnt = 0;
    int         checks = 0;
    int         cyc = 0;
    // Same source order as the mask word, highest bit first
    wire [7:0]  en_v = {comparator_one_irq_en_o, pin_change_irq_en_o,
        pulse_gen_four_irq_en_o, pulse_gen_three_irq_en_o,
        pulse_gen_two_irq_en_o, pulse_gen_one_irq_en_o,
        pulse_special_match_irq_en_o, ext_line_two_irq_en_o};
    wire [7:0]  req_v = {comparator_one_req_o, pin_change_req_o,
        pulse_gen_four_req_o, pulse_gen_three_req_o,
        pulse_gen_two_req_o, pulse_gen_one_req_o,
        pulse_special_match_req_o, ext_line_two_req_o};
    assign {comparator_one_pend_i, pin_change_pend_i, pulse_gen_four_pend_i,
        pulse_gen_three_pend_i, pulse_gen_two_pend_i, pulse_gen_one_pend_i,
        pulse_special_match_pend_i, ext_line_two_pend_i} = pend_q;
    iem_mask_bank_one iem_mask_bank_one_inst (.*);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input iem_data_t got, input iem_data_t exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Settle past the edge so its updates have landed
    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic wr(input iem_addr_t a, input iem_data_t d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input iem_addr_t a, input iem_data_t exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask : rd
    // ------------------------------------------------------------
    // Clock, timeout and tests
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 16'h0000;
        pend_q = 8'hff;
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        tick();
        chk({8'h00, en_v | req_v}, 16'h0000);
        rd(OFS_MASK, 16'h0000);
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            w = 16'h0001 << k;
            wr(OFS_MASK, w);
            chk({8'h00, en_v},
                {8'h00, w[13], w[11], w[6:1]});
            rd(OFS_MASK, w & 16'h287e);
        end
        $display("test bit walk done");
        wr(OFS_MASK, 16'hffff);
        rd(OFS_MASK, 16'h287e);
        wr(8'h0c, 16'h0000);
        wr(OFS_REQ, 16'h0000);
        rd(OFS_MASK, 16'h287e);
        rd(8'h0c, 16'h0000);
        $display("test unmapped done");
        wr(OFS_MASK, 16'h2878);
        tick();
        chk({8'h00, req_v}, 16'h00fc);
        chk({15'h0000, any_req_o}, 16'h0001);
        rd(OFS_REQ, 16'h2878);
        wr(OFS_MASK, 16'h0000);
        tick();
        chk({7'h00, any_req_o, req_v}, 16'h0000);
        rd(OFS_PEND, 16'h287e);
        @(posedge core_clk_i);
        pend_q <= 8'h81;
        wr(OFS_MASK, 16'h0002);
        tick();
        chk({8'h00, req_v}, 16'h0001);
        $display("test gating done");
        // Reset in mid-run must drop every enable and request
        wr(OFS_MASK, 16'hffff);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        tick();
        chk({7'h00, any_req_o, en_v | req_v}, 16'h0000);
        rd(OFS_MASK, 16'h0000);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule : iem_mask_bank_one_tb
bind iem_mask_bank_one iem_mask_bank_one_props
    iem_mask_bank_one_props_inst (.*);
